// *** hdl/isf_core.sv ***
// Two-wire serial slave with event flags, interrupt masking and register port
//
// How it works
// - Finished slave byte sets byte done flag
// - Data write, smart read, command clear byte done
// - Writing one clears byte done flag
// - Own address received sets address hit flag
// - Any control B write clears address hit
// - Writing one clears hit, sends chosen acknowledge
// - Stop in own transaction sets stop flag
// - Foreign stop sets flag only with group command
// - Command after address hit clears stop flag
// - Writing one clears stop seen flag
// - Writing zero leaves every flag unchanged
// - Smart mode acknowledges on data read
// - Any valid command clears all three flags
`default_nettype none
module isf_core (
  input  wire logic                          clock,
  input  wire logic                          rst_b,
  input  wire logic [isf_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [isf_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [isf_pkg::DATA_W-1:0]    reg_rdata,
  input  wire logic                          scl_in,
  output logic                               scl_out,
  output logic                               scl_oe_b,
  input  wire logic                          sda_in,
  output logic                               sda_out,
  output logic                               sda_oe_b,
  output logic                               irq
);
  isf_pkg::isf_state_t state_reg;
  isf_pkg::isf_state_t state_next;
  isf_pkg::isf_state_t after_reg;
  isf_pkg::isf_state_t after_next;

  logic [1:0]  pins_sync;
  logic        scl_s;
  logic        sda_s;
  logic        scl_d_reg;
  logic        sda_d_reg;
  logic        enable_reg;
  logic        smart_reg;
  logic        group_reg;
  logic        ack_act_reg;
  logic [6:0]  own_addr_reg;
  logic [2:0]  inten_reg;
  logic [2:0]  inten_next;
  logic [2:0]  flag_reg;
  logic [2:0]  flag_next;
  logic [2:0]  flag_set;
  logic [2:0]  flag_clr;
  logic [7:0]  tx_reg;
  logic [7:0]  rx_reg;
  logic [7:0]  rx_next;
  logic [7:0]  shift_reg;
  logic [7:0]  shift_next;
  logic [3:0]  cnt_reg;
  logic [3:0]  cnt_next;
  logic        sda_low_reg;
  logic        sda_low_next;
  logic        dir_reg;
  logic        dir_next;
  logic        sel_reg;
  logic        sel_next;
  logic        nack_reg;
  logic        nack_next;
  logic        nack_sent_reg;
  logic        nack_sent_next;
  logic        set_byte;
  logic        set_hit;
  logic        set_stop;
  logic [31:0] rd_word;

  isf_sync #(
    .W(2)
  ) u_sync (
    .clock    (clock),
    .rst_b    (rst_b),
    .async_in ({scl_in, sda_in}),
    .sync_out (pins_sync)
  );

  assign scl_s = pins_sync[1];
  assign sda_s = pins_sync[0];

  // Bus condition detection on the sampled lines
  wire scl_rise   = scl_s & ~scl_d_reg;
  wire scl_fall   = ~scl_s & scl_d_reg;
  wire start_det  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_det   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire byte_end   = scl_fall & (cnt_reg == isf_pkg::BITS_PER_BYTE);
  wire bit9_end   = scl_fall & (cnt_reg == 4'h1);

  // Register decode
  wire wr_ctrl_a  = reg_wr & (reg_addr == isf_pkg::OFF_CTRL_A);
  wire wr_ctrl_b  = reg_wr & (reg_addr == isf_pkg::OFF_CTRL_B);
  wire wr_int_clr = reg_wr & (reg_addr == isf_pkg::OFF_INT_CLR);
  wire wr_int_set = reg_wr & (reg_addr == isf_pkg::OFF_INT_SET);
  wire wr_flags   = reg_wr & (reg_addr == isf_pkg::OFF_FLAGS);
  wire wr_data    = reg_wr & (reg_addr == isf_pkg::OFF_DATA);
  wire wr_own     = reg_wr & (reg_addr == isf_pkg::OFF_OWN_ADDR);
  wire rd_data    = reg_rd & (reg_addr == isf_pkg::OFF_DATA);
  wire [1:0] cmd_val = reg_wdata[isf_pkg::POS_CMD_HI:isf_pkg::POS_CMD_LO];
  wire cmd_cont   = wr_ctrl_b & (cmd_val == isf_pkg::CMD_CONTINUE);
  wire cmd_wait   = wr_ctrl_b & (cmd_val == isf_pkg::CMD_WAIT_START);
  wire cmd_valid  = cmd_cont | cmd_wait;
  wire smart_rd   = rd_data & smart_reg;
  // A command takes the acknowledge action written beside it
  wire ack_now    = wr_ctrl_b ? reg_wdata[isf_pkg::POS_ACK_ACT] : ack_act_reg;
  wire w1_byte    = wr_flags & reg_wdata[isf_pkg::POS_BYTE_DONE];
  wire w1_hit     = wr_flags & reg_wdata[isf_pkg::POS_ADDR_HIT];
  wire w1_stop    = wr_flags & reg_wdata[isf_pkg::POS_STOP];
  wire hit_release = w1_hit & flag_reg[isf_pkg::POS_ADDR_HIT];
  wire [15:0] status_word = {13'h0000, nack_reg, dir_reg, (state_reg != isf_pkg::ISF_IDLE)};

  // Flag clear sources
  assign flag_clr[isf_pkg::POS_BYTE_DONE] = wr_data | smart_rd | cmd_valid | w1_byte;
  assign flag_clr[isf_pkg::POS_ADDR_HIT]  = wr_ctrl_b | w1_hit;
  assign flag_clr[isf_pkg::POS_STOP]      = cmd_valid | w1_stop;
  assign flag_set[isf_pkg::POS_BYTE_DONE] = set_byte;
  assign flag_set[isf_pkg::POS_ADDR_HIT]  = set_hit;
  assign flag_set[isf_pkg::POS_STOP]      = set_stop;
  // Set wins over clear; zero bits written clear nothing
  assign flag_next = flag_set | (flag_reg & ~flag_clr);

  assign inten_next = wr_int_set ? (inten_reg | reg_wdata[2:0]) :
                      wr_int_clr ? (inten_reg & ~reg_wdata[2:0]) : inten_reg;

  assign irq = |(flag_reg & inten_reg);

  assign rd_word =
    (reg_addr == isf_pkg::OFF_CTRL_A)   ? {30'h00000000, enable_reg, 1'b0} :
    (reg_addr == isf_pkg::OFF_CTRL_B)   ? {13'h0000, ack_act_reg, 2'h0, 7'h00, smart_reg,
                                           6'h00, group_reg, 1'b0} :
    (reg_addr == isf_pkg::OFF_INT_CLR)  ? {29'h00000000, inten_reg} :
    (reg_addr == isf_pkg::OFF_INT_SET)  ? {29'h00000000, inten_reg} :
    (reg_addr == isf_pkg::OFF_FLAGS)    ? {29'h00000000, flag_reg} :
    (reg_addr == isf_pkg::OFF_STATUS)   ? {16'h0000, status_word} :
    (reg_addr == isf_pkg::OFF_DATA)     ? {24'h000000, rx_reg} :
    (reg_addr == isf_pkg::OFF_OWN_ADDR) ? {25'h0000000, own_addr_reg} : 32'h00000000;

  // Open-drain drive: enables are low while pulling the line low
  assign sda_out  = 1'b0;
  assign scl_out  = 1'b0;
  assign sda_oe_b = ~sda_low_reg;
  assign scl_oe_b = ~((state_reg == isf_pkg::ISF_ADDR_HOLD) |
                      (state_reg == isf_pkg::ISF_RX_HOLD) |
                      (state_reg == isf_pkg::ISF_TX_HOLD));

  // Slave sequencer
  always_comb begin
    state_next     = state_reg;
    after_next     = after_reg;
    shift_next     = shift_reg;
    cnt_next       = cnt_reg;
    sda_low_next   = sda_low_reg;
    dir_next       = dir_reg;
    sel_next       = sel_reg;
    nack_next      = nack_reg;
    nack_sent_next = nack_sent_reg;
    rx_next        = rx_reg;
    set_byte       = 1'b0;
    set_hit        = 1'b0;
    set_stop       = 1'b0;
    if (!enable_reg) begin
      state_next   = isf_pkg::ISF_IDLE;
      sda_low_next = 1'b0;
      sel_next     = 1'b0;
    end else if (start_det) begin
      state_next   = isf_pkg::ISF_ADDR;
      cnt_next     = 4'h0;
      sda_low_next = 1'b0;
      sel_next     = 1'b0;
    end else if (stop_det) begin
      set_stop     = sel_reg | (group_reg & (state_reg != isf_pkg::ISF_IDLE));
      state_next   = isf_pkg::ISF_IDLE;
      sda_low_next = 1'b0;
      sel_next     = 1'b0;
    end else begin
      unique case (state_reg)
        isf_pkg::ISF_IDLE, isf_pkg::ISF_IGNORE: begin
        end
        isf_pkg::ISF_ADDR, isf_pkg::ISF_RX: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_s};
            cnt_next   = cnt_reg + 4'h1;
          end else if (byte_end) begin
            cnt_next = 4'h0;
            if (state_reg == isf_pkg::ISF_RX) begin
              rx_next    = shift_reg;
              set_byte   = 1'b1;
              state_next = isf_pkg::ISF_RX_HOLD;
            end else if (shift_reg[7:1] == own_addr_reg) begin
              set_hit    = 1'b1;
              sel_next   = 1'b1;
              dir_next   = shift_reg[0];
              state_next = isf_pkg::ISF_ADDR_HOLD;
            end else begin
              state_next = isf_pkg::ISF_IGNORE;
            end
          end
        end
        isf_pkg::ISF_ADDR_HOLD: begin
          if (hit_release | cmd_cont) begin
            state_next     = isf_pkg::ISF_ACK;
            after_next     = dir_reg ? isf_pkg::ISF_TX_HOLD : isf_pkg::ISF_RX;
            sda_low_next   = ~ack_now;
            nack_sent_next = ack_now;
            cnt_next       = 4'h0;
          end else if (cmd_wait) begin
            state_next = isf_pkg::ISF_IGNORE;
          end
        end
        isf_pkg::ISF_RX_HOLD: begin
          if (cmd_cont | cmd_wait | smart_rd) begin
            state_next     = isf_pkg::ISF_ACK;
            after_next     = cmd_wait ? isf_pkg::ISF_IGNORE : isf_pkg::ISF_RX;
            sda_low_next   = ~ack_now;
            nack_sent_next = ack_now;
            cnt_next       = 4'h0;
          end
        end
        isf_pkg::ISF_ACK: begin
          if (scl_rise) begin
            cnt_next = 4'h1;
          end else if (bit9_end) begin
            sda_low_next = 1'b0;
            cnt_next     = 4'h0;
            if (nack_sent_reg) begin
              state_next = isf_pkg::ISF_IGNORE;
            end else begin
              state_next = after_reg;
              set_byte   = (after_reg == isf_pkg::ISF_TX_HOLD);
            end
          end
        end
        isf_pkg::ISF_TX_HOLD: begin
          if (cmd_cont) begin
            state_next   = isf_pkg::ISF_TX;
            shift_next   = tx_reg;
            sda_low_next = ~tx_reg[7];
            cnt_next     = 4'h0;
          end else if (cmd_wait) begin
            state_next = isf_pkg::ISF_IGNORE;
          end
        end
        isf_pkg::ISF_TX: begin
          if (scl_rise) begin
            cnt_next = cnt_reg + 4'h1;
          end else if (byte_end) begin
            sda_low_next = 1'b0;
            cnt_next     = 4'h0;
            state_next   = isf_pkg::ISF_TX_ACK;
          end else if (scl_fall) begin
            shift_next   = {shift_reg[6:0], 1'b0};
            sda_low_next = ~shift_reg[6];
          end
        end
        isf_pkg::ISF_TX_ACK: begin
          if (scl_rise) begin
            nack_next = sda_s;
            cnt_next  = 4'h1;
          end else if (bit9_end) begin
            cnt_next = 4'h0;
            if (!nack_reg) begin
              set_byte   = 1'b1;
              state_next = isf_pkg::ISF_TX_HOLD;
            end else begin
              state_next = isf_pkg::ISF_IGNORE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg     <= isf_pkg::ISF_IDLE;
      after_reg     <= isf_pkg::ISF_RX;
      shift_reg     <= isf_pkg::RST_BYTE;
      cnt_reg       <= 4'h0;
      sda_low_reg   <= 1'b0;
      dir_reg       <= 1'b0;
      sel_reg       <= 1'b0;
      nack_reg      <= 1'b0;
      nack_sent_reg <= 1'b0;
      rx_reg        <= isf_pkg::RST_BYTE;
      flag_reg      <= isf_pkg::RST_FLAGS;
      inten_reg     <= isf_pkg::RST_INTEN;
      scl_d_reg     <= 1'b1;
      sda_d_reg     <= 1'b1;
    end else begin
      state_reg     <= state_next;
      after_reg     <= after_next;
      shift_reg     <= shift_next;
      cnt_reg       <= cnt_next;
      sda_low_reg   <= sda_low_next;
      dir_reg       <= dir_next;
      sel_reg       <= sel_next;
      nack_reg      <= nack_next;
      nack_sent_reg <= nack_sent_next;
      rx_reg        <= rx_next;
      flag_reg      <= flag_next;
      inten_reg     <= inten_next;
      scl_d_reg     <= scl_s;
      sda_d_reg     <= sda_s;
    end
  end

  // Software-written configuration
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      enable_reg   <= 1'b0;
      smart_reg    <= 1'b0;
      group_reg    <= 1'b0;
      ack_act_reg  <= 1'b0;
      own_addr_reg <= isf_pkg::RST_OWN_ADDR;
      tx_reg       <= isf_pkg::RST_BYTE;
    end else begin
      if (wr_ctrl_a) begin
        enable_reg <= reg_wdata[isf_pkg::POS_ENABLE];
      end
      if (wr_ctrl_b) begin
        smart_reg   <= reg_wdata[isf_pkg::POS_SMART];
        group_reg   <= reg_wdata[isf_pkg::POS_GROUP_CMD];
        ack_act_reg <= reg_wdata[isf_pkg::POS_ACK_ACT];
      end
      if (wr_own) begin
        own_addr_reg <= reg_wdata[6:0];
      end
      if (wr_data) begin
        tx_reg <= reg_wdata[7:0];
      end
    end
  end

  // Read data stand only in the cycle after the read strobe
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= reg_rd ? rd_word : 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// *** hdl/isf_pkg.sv ***
// Constants, register map and state type of the two-wire slave flag block
`default_nettype none
package isf_pkg;
  localparam int          DATA_W        = 32;
  localparam int          ADDR_W        = 8;
  // Register offsets
  localparam logic [7:0]  OFF_CTRL_A    = 8'h00;
  localparam logic [7:0]  OFF_CTRL_B    = 8'h04;
  localparam logic [7:0]  OFF_INT_CLR   = 8'h0C;
  localparam logic [7:0]  OFF_INT_SET   = 8'h0D;
  localparam logic [7:0]  OFF_FLAGS     = 8'h0E;
  localparam logic [7:0]  OFF_STATUS    = 8'h10;
  localparam logic [7:0]  OFF_DATA      = 8'h18;
  localparam logic [7:0]  OFF_OWN_ADDR  = 8'h24;
  // Field positions
  localparam int          POS_ENABLE    = 1;
  localparam int          POS_GROUP_CMD = 1;
  localparam int          POS_SMART     = 8;
  localparam int          POS_CMD_LO    = 16;
  localparam int          POS_CMD_HI    = 17;
  localparam int          POS_ACK_ACT   = 18;
  localparam int          POS_STOP      = 0;
  localparam int          POS_ADDR_HIT  = 1;
  localparam int          POS_BYTE_DONE = 2;
  // Commands
  localparam logic [1:0]  CMD_WAIT_START = 2'h2;
  localparam logic [1:0]  CMD_CONTINUE   = 2'h3;
  // Reset values and bits per byte
  localparam logic [2:0]  RST_FLAGS     = 3'h0;
  localparam logic [2:0]  RST_INTEN     = 3'h0;
  localparam logic [6:0]  RST_OWN_ADDR  = 7'h00;
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [15:0] RST_STATUS    = 16'h0000;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;

  typedef enum logic [3:0] {
    ISF_IDLE,
    ISF_ADDR,
    ISF_ADDR_HOLD,
    ISF_ACK,
    ISF_RX,
    ISF_RX_HOLD,
    ISF_TX_HOLD,
    ISF_TX,
    ISF_TX_ACK,
    ISF_IGNORE
  } isf_state_t;
endpackage
`default_nettype wire

// *** hdl/isf_sync.sv ***
// Two-flop synchroniser for pin inputs
`default_nettype none
module isf_sync #(
  parameter int W = 2
) (
  input  wire logic         clock,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '1;
      sync_out <= '1;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// *** tb/isf_chk.sv ***
// Concurrent checks on the flag slave register port and bus pins
`default_nettype none
module isf_chk (
  input wire logic                       clock,
  input wire logic                       rst_b,
  input wire logic [isf_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [isf_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [isf_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                       scl_in,
  input wire logic                       scl_out,
  input wire logic                       scl_oe_b,
  input wire logic                       sda_in,
  input wire logic                       sda_out,
  input wire logic                       sda_oe_b,
  input wire logic                       irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] en_reg;
  logic       ack_reg;
  logic       smart_reg;
  wire        wr_fl = reg_wr && reg_addr == isf_pkg::OFF_FLAGS;
  wire        wr_cb = reg_wr && reg_addr == isf_pkg::OFF_CTRL_B;
  wire        wr_dt = reg_wr && reg_addr == isf_pkg::OFF_DATA;
  wire        rd_en = reg_addr == isf_pkg::OFF_INT_CLR || reg_addr == isf_pkg::OFF_INT_SET;
  // Shadow of enables and control bits
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      en_reg    <= isf_pkg::RST_INTEN;
      ack_reg   <= 1'b0;
      smart_reg <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == isf_pkg::OFF_INT_SET) en_reg <= en_reg | reg_wdata[2:0];
      if (reg_wr && reg_addr == isf_pkg::OFF_INT_CLR) en_reg <= en_reg & ~reg_wdata[2:0];
      if (wr_cb) ack_reg <= reg_wdata[isf_pkg::POS_ACK_ACT];
      if (wr_cb) smart_reg <= reg_wdata[isf_pkg::POS_SMART];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_rd_fl;
    reg_rd && reg_addr == isf_pkg::OFF_FLAGS;
  endsequence
  property p_w1c;
    wr_fl ##2 s_rd_fl |=> (reg_rdata[2:0] & $past(reg_wdata[2:0], 3)) == 3'h0;
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag kept after write one");
  property p_cmd;
    (wr_cb && reg_wdata[isf_pkg::POS_CMD_HI]) ##2 s_rd_fl |=> reg_rdata[2:0] == 3'h0;
  endproperty
  a_cmd: assert property (p_cmd) else $error("flag kept after command");
  property p_cb_hit;
    wr_cb ##2 s_rd_fl |=> !reg_rdata[isf_pkg::POS_ADDR_HIT];
  endproperty
  a_cb_hit: assert property (p_cb_hit) else $error("hit kept after ctrl write");
  property p_dat_wr;
    wr_dt ##2 s_rd_fl |=> !reg_rdata[isf_pkg::POS_BYTE_DONE];
  endproperty
  a_dat_wr: assert property (p_dat_wr) else $error("byte flag kept after data write");
  property p_irq;
    s_rd_fl |=> ((reg_rdata[2:0] & $past(en_reg)) != 3'h0) == $past(irq);
  endproperty
  a_irq: assert property (p_irq) else $error("irq differs from flags and enables");
  property p_en_rd;
    reg_rd && rd_en |=> reg_rdata == {29'h0, $past(en_reg)};
  endproperty
  a_en_rd: assert property (p_en_rd) else $error("enable readback wrong");
  property p_idle;
    !reg_rd |=> reg_rdata == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("read data outside read cycle");
  property p_ack;
    wr_fl && reg_wdata[isf_pkg::POS_ADDR_HIT] && !scl_oe_b && !ack_reg
      |-> ##[1:8] (!sda_oe_b && scl_oe_b);
  endproperty
  a_ack: assert property (p_ack) else $error("no ack after hit clear");
  property p_smart;
    reg_rd && reg_addr == isf_pkg::OFF_DATA && smart_reg && !scl_oe_b |-> ##[1:8] scl_oe_b;
  endproperty
  a_smart: assert property (p_smart) else $error("smart read did not release");
endmodule
bind isf_core isf_chk u_chk (
  .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_in),
  .scl_out(scl_out), .scl_oe_b(scl_oe_b), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_b(sda_oe_b), .irq(irq)
);
`default_nettype wire

// *** tb/isf_master.sv ***
// Two-wire bus master model on open-drain lines with pull-ups
`default_nettype none
module isf_master (
  input  wire logic scl_line,
  input  wire logic sda_line,
  output logic      scl_rel,
  output logic      sda_rel
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
  end
  // One bit; waits while the slave stretches the clock
  task automatic bit_io(input logic b, output logic s);
    int n;
    n = 0;
    #40 sda_rel = b;
    #40 scl_rel = 1'b1;
    while (!scl_line && n < 5000) begin
      #20 n++;
    end
    #40 s = sda_line;
    #40 scl_rel = 1'b0;
  endtask
  task automatic start();
    sda_rel = 1'b1;
    scl_rel = 1'b1;
    #80 sda_rel = 1'b0;
    #80 scl_rel = 1'b0;
  endtask
  task automatic stop();
    #40 sda_rel = 1'b0;
    #40 scl_rel = 1'b1;
    #80 sda_rel = 1'b1;
    #80;
  endtask
  // Eight bits MSB first, then the acknowledge bit read back
  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], s);
    end
    #80 bit_io(1'b1, ack);
  endtask
  // Eight bits read MSB first, then the master's own acknowledge bit
  task automatic rbyte(input logic nack, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, v[i]);
    end
    #80 bit_io(nack, s);
  endtask
endmodule
`default_nettype wire

// *** tb/test_i2c_slave_interrupt_flags.sv ***
// Self-checking bench for the two-wire slave event flags
`default_nettype none
module test_i2c_slave_interrupt_flags;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        scl_out, scl_oe_b, sda_out, sda_oe_b, irq, scl_rel, sda_rel, ack;
  wire         scl_line = scl_rel & (scl_oe_b | scl_out);
  wire         sda_line = sda_rel & (sda_oe_b | sda_out);
  int          n_errors = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  logic [6:0]  own;
  logic [7:0]  d0, d1, rx;
  isf_core dut (
    .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_line),
    .scl_out(scl_out), .scl_oe_b(scl_oe_b), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_b(sda_oe_b), .irq(irq)
  );
  isf_master m (.scl_line(scl_line), .sda_line(sda_line), .scl_rel(scl_rel), .sda_rel(sda_rel));
  always #10 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  function automatic logic [31:0] cbv(input logic a, input logic [1:0] c, input logic s, g);
    return {13'h0, a, c, 7'h0, s, 6'h0, g, 1'b0};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic w, r, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, 1'b0, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, 1'b1, a, 32'h0);
    @(negedge clock);
    chk(reg_rdata, e);
  endtask
  task automatic rdf(input logic [31:0] e);
    rdc(isf_pkg::OFF_FLAGS, e);
  endtask
  task automatic wrf(input logic [31:0] d);
    wr(isf_pkg::OFF_FLAGS, d);
  endtask
  task automatic waitf(input int b);
    int n;
    n = 0;
    do begin
      acc(1'b0, 1'b1, isf_pkg::OFF_FLAGS, 32'h0);
      @(negedge clock);
      n++;
    end while (reg_rdata[b] !== 1'b1 && n < 2000);
    if (n >= 2000) n_errors++;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    void'($urandom(63));
    own = {1'b1, 6'($urandom())};
    d0 = 8'($urandom());
    d1 = 8'($urandom());
    rdf(32'h0);
    rdc(isf_pkg::OFF_INT_SET, 32'h0);
    rdc(8'hF0, 32'h0);
    wr(isf_pkg::OFF_OWN_ADDR, {25'h0, own});
    wr(isf_pkg::OFF_CTRL_A, 32'h2);
    wr(isf_pkg::OFF_INT_SET, 32'h7);
    rdc(isf_pkg::OFF_INT_CLR, 32'h7);
    fork
      begin
        m.start();
        m.wbyte({own, 1'b0}, ack);
        chk({31'h0, ack}, 32'h0);
        m.wbyte(d0, ack);
        chk({31'h0, ack}, 32'h0);
        m.wbyte(d1, ack);
        chk({31'h0, ack}, 32'h0);
        m.wbyte(d0, ack);
        chk({31'h0, ack}, 32'h1);
        m.stop();
      end
      begin
        waitf(1);
        rdf(32'h2);
        chk({31'h0, irq}, 32'h1);
        wrf(32'h0);
        rdf(32'h2);
        wrf(32'h2);
        waitf(2);
        rdc(isf_pkg::OFF_DATA, {24'h0, d0});
        rdf(32'h4);
        wrf(32'h4);
        rdf(32'h0);
        wr(isf_pkg::OFF_CTRL_B, cbv(1'b0, 2'h3, 1'b1, 1'b0));
        waitf(2);
        rdc(isf_pkg::OFF_DATA, {24'h0, d1});
        rdf(32'h0);
        waitf(2);
        wr(isf_pkg::OFF_DATA, 32'h5A);
        rdf(32'h0);
        wr(isf_pkg::OFF_CTRL_B, cbv(1'b1, 2'h2, 1'b1, 1'b0));
        waitf(0);
        rdf(32'h1);
        wr(isf_pkg::OFF_INT_CLR, 32'h1);
        @(negedge clock);
        chk({31'h0, irq}, 32'h0);
        wrf(32'h1);
        rdf(32'h0);
      end
    join
    for (int g = 0; g < 2; g++) begin
      wr(isf_pkg::OFF_CTRL_B, cbv(1'b0, 2'h0, 1'b0, g[0]));
      m.start();
      m.wbyte({own ^ 7'h01, 1'b0}, ack);
      chk({31'h0, ack}, 32'h1);
      m.stop();
      rdf(32'(g));
    end
    fork
      begin
        m.start();
        m.wbyte({own, 1'b0}, ack);
        chk({31'h0, ack}, 32'h0);
        m.stop();
      end
      begin
        waitf(1);
        rdf(32'h3);
        wr(isf_pkg::OFF_CTRL_B, cbv(1'b0, 2'h3, 1'b0, 1'b1));
        rdf(32'h0);
      end
    join
    fork
      begin
        m.start();
        m.wbyte({own, 1'b1}, ack);
        chk({31'h0, ack}, 32'h0);
        m.rbyte(1'b1, rx);
        chk({24'h0, rx}, {24'h0, d1});
        m.stop();
      end
      begin
        waitf(1);
        wr(isf_pkg::OFF_DATA, {24'h0, d1});
        wrf(32'h2);
        waitf(2);
        rdf(32'h5);
        wr(isf_pkg::OFF_CTRL_B, cbv(1'b0, 2'h3, 1'b0, 1'b0));
        rdf(32'h0);
      end
    join
    rdf(32'h1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
